// ---- core/sdt_pkg.sv ----
// shared constants and types of the split dual byte timer control block
package sdt_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CLK_SRC  = 6'h00;
  localparam logic [5:0] IDX_OUT_EN   = 6'h01;
  localparam logic [5:0] IDX_OUT_VAL  = 6'h02;
  localparam logic [5:0] IDX_MODE     = 6'h04;
  localparam logic [5:0] IDX_UNF_LVL  = 6'h06;
  localparam logic [5:0] IDX_CMP_LVL  = 6'h07;
  localparam logic [5:0] IDX_CMD      = 6'h08;
  localparam logic [5:0] IDX_FLAGS    = 6'h0C;
  localparam logic [5:0] IDX_LO_COUNT = 6'h20;
  localparam logic [5:0] IDX_HI_COUNT = 6'h21;
  localparam logic [5:0] IDX_HI_PER   = 6'h26;
  localparam logic [5:0] IDX_LO_PER   = 6'h27;
  localparam logic [5:0] IDX_LO_CMP   = 6'h28; // channels a..d at 28..2B
  localparam logic [5:0] IDX_HI_CMP   = 6'h2C; // channels a..d at 2C..2F
  // clock source codes
  localparam logic [3:0] CLK_OFF      = 4'h0;
  localparam int         CLK_EVT_BIT  = 3;
  localparam int         PRE_TAPS     = 7;
  localparam int         PRE_WIDTH    = 10;
  // mode codes
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_BYTE    = 2'h1;
  localparam logic [1:0] MODE_SPLIT   = 2'h2;
  // command codes and target bits
  localparam logic [1:0] CMD_RESTART  = 2'h2;
  localparam logic [1:0] CMD_RESET    = 2'h3;
  localparam int         CMD_LSB      = 2;
  localparam int         TGT_LO_BIT   = 0;
  localparam int         TGT_HI_BIT   = 1;
  // flag register layout
  localparam int         FLG_LO_UNF   = 0;
  localparam int         FLG_HI_UNF   = 1;
  localparam int         FLG_CMP_LSB  = 4;
  // reset values
  localparam logic [7:0] RST_BYTE     = 8'h00;
  // avalon request bundle
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } sdt_bus_req_t;
endpackage

// ---- core/sdt_prescaler.sv ----
// free running prescaler giving one cycle enables for the divided clocks
`timescale 1ns/1ps
`default_nettype none
module sdt_prescaler (
  input  wire logic                        clock_i, // peripheral clock
  input  wire logic                        reset_i, // sync reset, high
  output logic [sdt_pkg::PRE_TAPS-1:0]     taps_o   // div 1,2,4,8,64,256,1024
);
  logic [sdt_pkg::PRE_WIDTH-1:0] count;        // divider count
  logic [sdt_pkg::PRE_TAPS-1:0]  next_taps;    // decoded taps
  // tap 0 is always on; each other tap pulses when its low count bits are all ones
  assign next_taps[0] = 1'b1;
  assign next_taps[1] = &count[0:0];
  assign next_taps[2] = &count[1:0];
  assign next_taps[3] = &count[2:0];
  assign next_taps[4] = &count[5:0];
  assign next_taps[5] = &count[7:0];
  assign next_taps[6] = &count[9:0];
  // count and register the taps so every output comes from a flop
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      count  <= '0;
      taps_o <= '0;
    end
    else
    begin
      count  <= count + 10'h001;
      taps_o <= next_taps;
    end
  end
endmodule
`default_nettype wire

// ---- core/sdt_half_wave.sv ----
// four compare channels and waveform generators of one eight bit half
`timescale 1ns/1ps
`default_nettype none
module sdt_half_wave (
  input  wire logic             clock_i,   // peripheral clock
  input  wire logic             reset_i,   // sync reset, high
  input  wire logic             tick_i,    // counter clock enable
  input  wire logic             stopped_i, // clock source is off
  input  wire logic             clear_i,   // restart or reset of this half
  input  wire logic [7:0]       count_i,   // current half count
  input  wire logic [3:0][7:0]  cmp_i,     // compare values a..d
  input  wire logic             force_i,   // software writes the levels
  input  wire logic [3:0]       level_i,   // levels to force
  output logic [3:0]            wave_o,    // waveform outputs
  output logic [3:0]            match_o    // one cycle compare pulses
);
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_ch
      logic hit; // count equals compare
      assign hit = (count_i == cmp_i[ch]);
      // bottom wins over a match when compare is zero
      always_ff @(posedge clock_i)
      begin
        if (reset_i || clear_i)
          wave_o[ch] <= 1'b0;
        else if (stopped_i && force_i)
          wave_o[ch] <= level_i[ch];
        else if (tick_i && count_i == 8'h00)
          wave_o[ch] <= 1'b0;
        else if (tick_i && hit)
          wave_o[ch] <= 1'b1;
        match_o[ch] <= !reset_i && tick_i && hit;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ---- core/sdt_timer_ctrl.sv ----
// control registers, clock select, counters and commands of the split timer
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - code 0 stops, 1..7 pick prescaler taps
// - top bit set selects event channel 0..7
// - one clock choice drives both halves
// - enable bits route waveforms onto pins
// - while stopped, software forces waveform levels
// - mode 00 is 16-bit, 11 reserved
// - mode 01 clears upper byte each tick
// - mode 10 runs two independent halves
// - high underflow level at bits 3:2
// - low underflow level at bits 1:0
// - four low compare levels, d topmost
// - command field always reads zero
// - 10 restarts, 11 resets only when stopped
// - target field picks low, high or both
// - restart clears counter and compare outputs
// - accepted reset restores initial register values
// - halves count down, reload from period
// - wave set on match, cleared at bottom
module sdt_timer_ctrl (
  input  wire logic                  clock_i,      // 200 MHz peripheral clock
  input  wire logic                  reset_i,      // sync reset, high
  input  wire sdt_pkg::sdt_bus_req_t bus_i,        // avalon request
  output logic                       waitrequest_o,// avalon stall
  output logic [31:0]                readdata_o,   // avalon read data
  input  wire logic [7:0]            event_i,      // async event channels
  input  wire logic [7:0]            port_out_i,   // port output register
  output logic [7:0]                 pin_o,        // compare output pins
  output logic [1:0]                 lo_unf_irq_o, // low underflow request level
  output logic [1:0]                 hi_unf_irq_o, // high underflow request level
  output logic [7:0]                 cmp_irq_o     // low compare request levels
);
  // registers
  logic [3:0]      clk_code;     // clock source code
  logic [7:0]      out_en;       // compare output enables
  logic [1:0]      mode;         // counter mode field
  logic [3:0]      unf_lvl;      // underflow levels
  logic [7:0]      cmp_lvl;      // low compare levels
  logic [1:0]      target;       // last command target
  logic [7:0]      lo_count;     // low half counter
  logic [7:0]      hi_count;     // high half counter
  logic [7:0]      lo_per;       // low period
  logic [7:0]      hi_per;       // high period
  logic [3:0][7:0] lo_cmp;       // low compare values
  logic [3:0][7:0] hi_cmp;       // high compare values
  logic            lo_unf_flag;  // low underflow flag
  logic            hi_unf_flag;  // high underflow flag
  logic [3:0]      cmp_flag;     // low compare flags
  logic            ack;          // bus answer cycle
  // event synchroniser stages, the first is read only by the second
  logic [7:0]      evt_meta;
  logic [7:0]      evt_sync;
  logic [7:0]      evt_last;
  logic [sdt_pkg::PRE_TAPS-1:0] taps; // registered prescaler enables

  // bus decode
  logic [5:0] idx;        // register index
  logic       wr_take;    // write takes effect this edge
  logic [7:0] wd;         // write data lane 0
  assign idx = bus_i.address[7:2];
  assign wr_take = bus_i.write && ack && bus_i.byteenable[0];
  assign wd = bus_i.writedata[7:0];
  assign waitrequest_o = (bus_i.read || bus_i.write) && !ack;

  logic we_clk, we_en, we_val, we_mode, we_unf, we_cmpl, we_cmd, we_flg;
  logic we_lc, we_hc, we_lp, we_hp, we_lcmp, we_hcmp;
  assign we_clk  = wr_take && idx == sdt_pkg::IDX_CLK_SRC;
  assign we_en   = wr_take && idx == sdt_pkg::IDX_OUT_EN;
  assign we_val  = wr_take && idx == sdt_pkg::IDX_OUT_VAL;
  assign we_mode = wr_take && idx == sdt_pkg::IDX_MODE;
  assign we_unf  = wr_take && idx == sdt_pkg::IDX_UNF_LVL;
  assign we_cmpl = wr_take && idx == sdt_pkg::IDX_CMP_LVL;
  assign we_cmd  = wr_take && idx == sdt_pkg::IDX_CMD;
  assign we_flg  = wr_take && idx == sdt_pkg::IDX_FLAGS;
  assign we_lc   = wr_take && idx == sdt_pkg::IDX_LO_COUNT;
  assign we_hc   = wr_take && idx == sdt_pkg::IDX_HI_COUNT;
  assign we_lp   = wr_take && idx == sdt_pkg::IDX_LO_PER;
  assign we_hp   = wr_take && idx == sdt_pkg::IDX_HI_PER;
  assign we_lcmp = wr_take && idx[5:2] == sdt_pkg::IDX_LO_CMP[5:2];
  assign we_hcmp = wr_take && idx[5:2] == sdt_pkg::IDX_HI_CMP[5:2];

  // commands; the code is never stored, so it reads back as zero
  logic [1:0] cmd_code;   // command code written
  logic       stopped;    // clock source off
  logic       do_restart; // restart command written
  logic       do_reset;   // reset command accepted
  logic       clr_lo;     // low half cleared this edge
  logic       clr_hi;     // high half cleared this edge
  logic       rst_lo;     // low half registers restored
  logic       rst_hi;     // high half registers restored
  assign cmd_code   = wd[sdt_pkg::CMD_LSB +: 2];
  assign stopped    = clk_code == sdt_pkg::CLK_OFF;
  assign do_restart = we_cmd && cmd_code == sdt_pkg::CMD_RESTART;
  assign do_reset   = we_cmd && cmd_code == sdt_pkg::CMD_RESET && stopped;
  // target 00 names no half, so nothing happens
  assign rst_lo = do_reset && wd[sdt_pkg::TGT_LO_BIT];
  assign rst_hi = do_reset && wd[sdt_pkg::TGT_HI_BIT];
  assign clr_lo = rst_lo || (do_restart && wd[sdt_pkg::TGT_LO_BIT]);
  assign clr_hi = rst_hi || (do_restart && wd[sdt_pkg::TGT_HI_BIT]);
  logic rst_any;          // shared control registers restored
  assign rst_any = rst_lo || rst_hi;

  // clock selection, shared by both halves
  logic [7:0] evt_edge;   // rising edges of synced events
  logic       tick;       // counter clock enable
  assign evt_edge = evt_sync & ~evt_last;
  assign tick = clk_code[sdt_pkg::CLK_EVT_BIT] ? evt_edge[clk_code[2:0]]
              : (stopped ? 1'b0 : taps[clk_code[2:0] - 3'h1]);

  // counting
  logic [15:0] full;      // both halves as one counter
  logic [15:0] full_dec;  // next 16-bit value
  logic [7:0]  next_lo;   // next low count on a tick
  logic [7:0]  next_hi;   // next high count on a tick
  logic        lo_zero;   // low half at bottom
  logic        hi_zero;   // high half at bottom
  logic        full_zero; // whole counter at bottom
  logic        split;     // dual half mode
  logic        lo_unf;    // low underflow event
  logic        hi_unf;    // high underflow event
  assign full      = {hi_count, lo_count};
  assign full_zero = full == 16'h0000;
  assign lo_zero   = lo_count == 8'h00;
  assign hi_zero   = hi_count == 8'h00;
  assign split     = mode == sdt_pkg::MODE_SPLIT;
  assign full_dec  = full_zero ? {hi_per, lo_per} : full - 16'h0001;
  assign next_lo   = split ? (lo_zero ? lo_per : lo_count - 8'h01)
                   : full_dec[7:0];
  assign next_hi   = split ? (hi_zero ? hi_per : hi_count - 8'h01)
                   : (mode == sdt_pkg::MODE_BYTE ? 8'h00 : full_dec[15:8]);
  // in byte mode the upper byte is already zero, so the low byte decides
  assign lo_unf = tick && (split ? lo_zero : full_zero);
  assign hi_unf = tick && split && hi_zero;
  // reserved mode 11 holds the counters still
  logic run_cnt;          // counting allowed by mode
  assign run_cnt = tick && mode != 2'h3;

  // waveform halves
  logic [3:0] lo_wave;    // low waveforms
  logic [3:0] hi_wave;    // high waveforms
  logic [3:0] lo_match;   // low compare pulses
  sdt_half_wave u_lo (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .tick_i    (run_cnt),
    .stopped_i (stopped),
    .clear_i   (clr_lo),
    .count_i   (lo_count),
    .cmp_i     (lo_cmp),
    .force_i   (we_val),
    .level_i   (wd[3:0]),
    .wave_o    (lo_wave),
    .match_o   (lo_match)
  );
  sdt_half_wave u_hi (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .tick_i    (run_cnt && split),
    .stopped_i (stopped),
    .clear_i   (clr_hi),
    .count_i   (hi_count),
    .cmp_i     (hi_cmp),
    .force_i   (we_val),
    .level_i   (wd[7:4]),
    .wave_o    (hi_wave),
    .match_o   ()
  );
  sdt_prescaler u_pre (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .taps_o  (taps)
  );

  // read mux; reserved bits read zero
  logic [7:0] rd_mux;     // selected register
  assign rd_mux =
      idx == sdt_pkg::IDX_CLK_SRC  ? {4'h0, clk_code}
    : idx == sdt_pkg::IDX_OUT_EN   ? out_en
    : idx == sdt_pkg::IDX_OUT_VAL  ? {hi_wave, lo_wave}
    : idx == sdt_pkg::IDX_MODE     ? {6'h00, mode}
    : idx == sdt_pkg::IDX_UNF_LVL  ? {4'h0, unf_lvl}
    : idx == sdt_pkg::IDX_CMP_LVL  ? cmp_lvl
    : idx == sdt_pkg::IDX_CMD      ? {4'h0, 2'h0, target}
    : idx == sdt_pkg::IDX_FLAGS    ? {cmp_flag, 2'h0, hi_unf_flag, lo_unf_flag}
    : idx == sdt_pkg::IDX_LO_COUNT ? lo_count
    : idx == sdt_pkg::IDX_HI_COUNT ? hi_count
    : idx == sdt_pkg::IDX_LO_PER   ? lo_per
    : idx == sdt_pkg::IDX_HI_PER   ? hi_per
    : idx[5:2] == sdt_pkg::IDX_LO_CMP[5:2] ? lo_cmp[idx[1:0]]
    : idx[5:2] == sdt_pkg::IDX_HI_CMP[5:2] ? hi_cmp[idx[1:0]]
    : 8'h00;

  // bus answer: one wait cycle, data captured before the answer edge
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      ack        <= 1'b0;
      readdata_o <= '0;
    end
    else
    begin
      ack        <= (bus_i.read || bus_i.write) && !ack;
      readdata_o <= {24'h000000, rd_mux};
    end
  end

  // event synchroniser and edge history
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      evt_meta <= '0;
      evt_sync <= '0;
      evt_last <= '0;
    end
    else
    begin
      evt_meta <= event_i;
      evt_sync <= evt_meta;
      evt_last <= evt_sync;
    end
  end

  // shared control registers
  always_ff @(posedge clock_i)
  begin
    if (reset_i || rst_any)
    begin
      clk_code <= sdt_pkg::RST_BYTE[3:0];
      mode     <= sdt_pkg::RST_BYTE[1:0];
      unf_lvl  <= sdt_pkg::RST_BYTE[3:0];
      cmp_lvl  <= sdt_pkg::RST_BYTE;
      target   <= sdt_pkg::RST_BYTE[1:0];
    end
    else
    begin
      if (we_clk)
        clk_code <= wd[3:0];
      if (we_mode)
        mode <= wd[1:0];
      if (we_unf)
        unf_lvl <= wd[3:0];
      if (we_cmpl)
        cmp_lvl <= wd;
      if (we_cmd)
        target <= wd[1:0];
    end
  end

  // output enables, one nibble per half
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      out_en <= sdt_pkg::RST_BYTE;
    else
    begin
      if (we_en)
        out_en <= wd;
      if (rst_lo)
        out_en[3:0] <= 4'h0;
      if (rst_hi)
        out_en[7:4] <= 4'h0;
    end
  end

  // low half counter, period and compares; bus writes beat counting
  always_ff @(posedge clock_i)
  begin
    if (reset_i || rst_lo)
    begin
      lo_count <= sdt_pkg::RST_BYTE;
      lo_per   <= sdt_pkg::RST_BYTE;
      lo_cmp   <= '0;
    end
    else
    begin
      if (clr_lo)
        lo_count <= 8'h00;
      else if (we_lc)
        lo_count <= wd;
      else if (run_cnt)
        lo_count <= next_lo;
      if (we_lp)
        lo_per <= wd;
      if (we_lcmp)
        lo_cmp[idx[1:0]] <= wd;
    end
  end

  // high half; in byte mode it is held at zero on every tick
  always_ff @(posedge clock_i)
  begin
    if (reset_i || rst_hi)
    begin
      hi_count <= sdt_pkg::RST_BYTE;
      hi_per   <= sdt_pkg::RST_BYTE;
      hi_cmp   <= '0;
    end
    else
    begin
      if (clr_hi)
        hi_count <= 8'h00;
      else if (we_hc)
        hi_count <= wd;
      else if (run_cnt)
        hi_count <= next_hi;
      if (we_hp)
        hi_per <= wd;
      if (we_hcmp)
        hi_cmp[idx[1:0]] <= wd;
    end
  end

  // flags: write one clears, a same-cycle event wins over the clear
  logic [3:0] cmp_clr;    // compare flag clears
  assign cmp_clr = we_flg ? wd[sdt_pkg::FLG_CMP_LSB +: 4] : 4'h0;
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      lo_unf_flag <= 1'b0;
      hi_unf_flag <= 1'b0;
      cmp_flag    <= 4'h0;
    end
    else
    begin
      lo_unf_flag <= lo_unf || (lo_unf_flag && !rst_lo
                     && !(we_flg && wd[sdt_pkg::FLG_LO_UNF]));
      hi_unf_flag <= hi_unf || (hi_unf_flag && !rst_hi
                     && !(we_flg && wd[sdt_pkg::FLG_HI_UNF]));
      cmp_flag    <= lo_match | (rst_lo ? 4'h0 : cmp_flag & ~cmp_clr);
    end
  end

  // pin override and interrupt request levels, all from flops
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++)
    begin : g_irq
      always_ff @(posedge clock_i)
      begin
        if (reset_i)
          cmp_irq_o[2*ch +: 2] <= 2'h0;
        else
          cmp_irq_o[2*ch +: 2] <= cmp_flag[ch] ? cmp_lvl[2*ch +: 2] : 2'h0;
      end
    end
  endgenerate
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      pin_o        <= 8'h00;
      lo_unf_irq_o <= 2'h0;
      hi_unf_irq_o <= 2'h0;
    end
    else
    begin
      pin_o        <= (out_en & {hi_wave, lo_wave}) | (~out_en & port_out_i);
      lo_unf_irq_o <= lo_unf_flag ? unf_lvl[1:0] : 2'h0;
      hi_unf_irq_o <= hi_unf_flag ? unf_lvl[3:2] : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ---- dv/sdt_timer_ctrl_chk.sv ----
// assertion checker for the split timer control block
`timescale 1ns/1ps
`default_nettype none
module sdt_timer_ctrl_chk (
  input  wire logic                  clock_i,       // clock
  input  wire logic                  reset_i,       // sync reset
  input  wire sdt_pkg::sdt_bus_req_t bus_i,         // bus request
  input  wire logic                  waitrequest_o, // bus stall
  input  wire logic [31:0]           readdata_o,    // read data
  input  wire logic [7:0]            event_i,       // event channels
  input  wire logic [7:0]            port_out_i,    // port values
  input  wire logic [7:0]            pin_o,         // output pins
  input  wire logic [1:0]            lo_unf_irq_o,  // low underflow level
  input  wire logic [1:0]            hi_unf_irq_o,  // high underflow level
  input  wire logic [7:0]            cmp_irq_o      // compare levels
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic [3:0] clk; // shadow clock select
  logic [7:0] en;  // shadow compare enables
  logic [7:0] ul;  // shadow underflow levels
  logic [7:0] cl;  // shadow compare levels
  wire  [5:0] ix    = bus_i.address[7:2];                           // word index
  wire        rdone = bus_i.read && !waitrequest_o;                 // read lands
  wire        wdone = bus_i.write && !waitrequest_o && bus_i.byteenable[0]; // write lands
  wire  [7:0] wd    = bus_i.writedata[7:0];                         // write byte
  // accepted reset needs a stopped timer and a real target
  wire        hrst  = wdone && ix == sdt_pkg::IDX_CMD && wd[3:2] == sdt_pkg::CMD_RESET
                      && wd[1:0] != 2'h0 && clk == 4'h0;
  // shadows follow landed writes; a reset clears shared fields and the targeted enables
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      {clk, en, ul, cl} <= 28'h0;
    else if (hrst)
      {clk, en, ul, cl} <= {4'h0, en & ~{{4{wd[1]}}, {4{wd[0]}}}, 16'h0};
    else if (wdone)
    begin
      if (ix == sdt_pkg::IDX_CLK_SRC)
        clk <= wd[3:0];
      if (ix == sdt_pkg::IDX_OUT_EN)
        en <= wd;
      if (ix == sdt_pkg::IDX_UNF_LVL)
        ul <= wd;
      if (ix == sdt_pkg::IDX_CMP_LVL)
        cl <= wd;
    end
  end
  property p_wait_idle; !(bus_i.read || bus_i.write) |-> !waitrequest_o; endproperty
  property p_wait_one; (bus_i.read || bus_i.write) && waitrequest_o |=> !waitrequest_o; endproperty
  property p_cmd_zero; rdone && ix == sdt_pkg::IDX_CMD |-> readdata_o[3:2] == 2'h0; endproperty
  property p_clk_rd; rdone && ix == sdt_pkg::IDX_CLK_SRC |-> readdata_o == {28'h0, clk}; endproperty
  property p_lvl_rd; rdone && ix == sdt_pkg::IDX_UNF_LVL |-> readdata_o == {24'h0, ul}; endproperty
  property p_pin;
    !$past(reset_i) |-> (pin_o & ~$past(en)) == ($past(port_out_i) & ~$past(en));
  endproperty
  property p_unf;
    !$past(reset_i) |-> (lo_unf_irq_o == 2'h0 || lo_unf_irq_o == $past(ul[1:0]))
      && (hi_unf_irq_o == 2'h0 || hi_unf_irq_o == $past(ul[3:2]));
  endproperty
  property p_cmp;
    !$past(reset_i) |-> (cmp_irq_o[1:0] == 2'h0 || cmp_irq_o[1:0] == $past(cl[1:0]))
      && (cmp_irq_o[3:2] == 2'h0 || cmp_irq_o[3:2] == $past(cl[3:2]))
      && (cmp_irq_o[5:4] == 2'h0 || cmp_irq_o[5:4] == $past(cl[5:4]))
      && (cmp_irq_o[7:6] == 2'h0 || cmp_irq_o[7:6] == $past(cl[7:6]));
  endproperty
  a_wait_idle:
    assert property (p_wait_idle) else $error("stall with no request");
  a_wait_one:
    assert property (p_wait_one) else $error("stall longer than one cycle");
  a_cmd_zero:
    assert property (p_cmd_zero) else $error("command code read nonzero");
  a_clk_rd:
    assert property (p_clk_rd) else $error("clock select readback wrong");
  a_lvl_rd:
    assert property (p_lvl_rd) else $error("underflow level readback wrong");
  a_pin:
    assert property (p_pin) else $error("disabled pin not from port");
  a_unf:
    assert property (p_unf) else $error("underflow request level wrong");
  a_cmp:
    assert property (p_cmp) else $error("compare request level wrong");
  c_reset: cover property (hrst);
  c_unf: cover property (lo_unf_irq_o != 2'h0);
  c_cmd: cover property (rdone && ix == sdt_pkg::IDX_CMD);
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the split timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                  clock_i = 1'b0;     // 200 MHz clock
  logic                  reset_i = 1'b1;     // sync reset
  sdt_pkg::sdt_bus_req_t bus_i = '0;         // bus request
  logic                  waitrequest_o;      // bus stall
  logic [31:0]           readdata_o;         // read data
  logic [7:0]            event_i = 8'h00;    // event channels
  logic [7:0]            port_out_i = 8'h00; // port values
  logic [7:0]            pin_o;              // output pins
  logic [1:0]            lo_unf_irq_o;       // low underflow request
  logic [1:0]            hi_unf_irq_o;       // high underflow request
  logic [7:0]            cmp_irq_o;          // compare requests
  int                    n_fail = 0;         // mismatches
  int                    samples_checked = 0; // comparisons
  logic [7:0]            q;                  // last read byte
  int                    divs [8] = '{0, 1, 2, 4, 8, 64, 256, 1024}; // tap dividers
  always #2.5 clock_i = ~clock_i;
  sdt_timer_ctrl DUT (.clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i), .waitrequest_o(waitrequest_o),
    .readdata_o(readdata_o), .event_i(event_i), .port_out_i(port_out_i), .pin_o(pin_o),
    .lo_unf_irq_o(lo_unf_irq_o), .hi_unf_irq_o(hi_unf_irq_o), .cmp_irq_o(cmp_irq_o));
  // verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // compare two counts
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %0d want %0d", $time, got, exp);
    end
  endtask
  // one bus access, held until the stall drops; one idle edge after
  task automatic acc(input logic w, input logic [5:0] ix, input logic [7:0] d);
    int k;
    bus_i.address <= {ix, 2'b00};
    bus_i.read <= !w;
    bus_i.write <= w;
    bus_i.writedata <= {24'h0, d};
    bus_i.byteenable <= 4'hF;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (waitrequest_o !== 1'b0 && k < 64);
    q = readdata_o[7:0];
    if (k >= 64)
      chk(0, 1);
    if (k >= 64)
      wrap_up();
    bus_i.read <= 1'b0;
    bus_i.write <= 1'b0;
    @(posedge clock_i);
  endtask
  // read a register and judge the byte; unknown bits never match
  task automatic rdc(input logic [5:0] ix, input logic [7:0] exp);
    acc(1'b0, ix, 8'h00);
    samples_checked++;
    if (q !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: reg %h got %h want %h", $time, ix, q, exp);
    end
  endtask
  // run n cycles pulsing the masked events, counting high cycles of two pins
  task automatic meas(input int n, input logic [7:0] ev, output int lo, output int hi);
    lo = 0;
    hi = 0;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock_i);
      event_i <= i[1] ? ev : 8'h00;
      lo += (pin_o[0] === 1'b1);
      hi += (pin_o[4] === 1'b1);
    end
  endtask
  // reset values of words 0..8, unmapped words among them
  task automatic t_defaults();
    for (int j = 0; j < 9; j++)
      rdc(j[5:0], 8'h00);
    acc(1'b1, 6'h03, 8'h5A);
    rdc(6'h03, 8'h00);
  endtask
  // forced levels and pin override while stopped
  task automatic t_pins();
    port_out_i <= 8'hA5;
    acc(1'b1, sdt_pkg::IDX_OUT_VAL, 8'h3C);
    rdc(sdt_pkg::IDX_OUT_VAL, 8'h3C);
    acc(1'b1, sdt_pkg::IDX_OUT_EN, 8'h0F);
    repeat (2) @(posedge clock_i);
    chk(pin_o, 8'hAC);
    acc(1'b1, sdt_pkg::IDX_OUT_EN, 8'hF0);
    repeat (2) @(posedge clock_i);
    chk(pin_o, 8'h35);
  endtask
  // reset command: inert target, refused while running, low half only when stopped
  task automatic t_cmd();
    acc(1'b1, sdt_pkg::IDX_UNF_LVL, 8'h0F);
    acc(1'b1, sdt_pkg::IDX_MODE, 8'h02);
    acc(1'b1, sdt_pkg::IDX_CMD, 8'h0C);
    rdc(sdt_pkg::IDX_UNF_LVL, 8'h0F);
    acc(1'b1, sdt_pkg::IDX_CLK_SRC, 8'h01);
    acc(1'b1, sdt_pkg::IDX_CMD, 8'h0F);
    rdc(sdt_pkg::IDX_UNF_LVL, 8'h0F);
    acc(1'b1, sdt_pkg::IDX_CLK_SRC, 8'h00);
    acc(1'b1, sdt_pkg::IDX_OUT_EN, 8'hFF);
    acc(1'b1, sdt_pkg::IDX_CMD, 8'h0D);
    rdc(sdt_pkg::IDX_CMD, 8'h00);
    rdc(sdt_pkg::IDX_UNF_LVL, 8'h00);
    rdc(sdt_pkg::IDX_MODE, 8'h00);
    rdc(sdt_pkg::IDX_OUT_EN, 8'hF0);
  endtask
  // restart of the low half leaves the high half alone
  task automatic t_restart();
    acc(1'b1, sdt_pkg::IDX_LO_COUNT, 8'h05);
    acc(1'b1, sdt_pkg::IDX_HI_COUNT, 8'h06);
    acc(1'b1, sdt_pkg::IDX_OUT_VAL, 8'h11);
    acc(1'b1, sdt_pkg::IDX_CMD, 8'h09);
    rdc(sdt_pkg::IDX_LO_COUNT, 8'h00);
    rdc(sdt_pkg::IDX_HI_COUNT, 8'h06);
    rdc(sdt_pkg::IDX_OUT_VAL, 8'h10);
  endtask
  // split halves on clock codes 1..15; duty of each half shows its period and compare
  task automatic t_run();
    int lo;
    int hi;
    int dv;
    acc(1'b1, sdt_pkg::IDX_MODE, 8'h02);
    acc(1'b1, sdt_pkg::IDX_LO_PER, 8'h03);
    acc(1'b1, sdt_pkg::IDX_HI_PER, 8'h07);
    acc(1'b1, sdt_pkg::IDX_LO_CMP, 8'h02);
    acc(1'b1, sdt_pkg::IDX_HI_CMP, 8'h07);
    acc(1'b1, sdt_pkg::IDX_OUT_EN, 8'h11);
    acc(1'b1, sdt_pkg::IDX_UNF_LVL, 8'h0E);
    acc(1'b1, sdt_pkg::IDX_CMP_LVL, 8'h1B);
    for (int c = 1; c < 16; c++)
    begin
      dv = (c < 8) ? divs[c] : 4; // events pulse every 4 cycles
      acc(1'b1, sdt_pkg::IDX_CLK_SRC, c[7:0]);
      meas(8 * dv, (c < 8) ? 8'h00 : 8'h01 << (c - 8), lo, hi);
      meas(8 * dv, (c < 8) ? 8'h00 : 8'h01 << (c - 8), lo, hi);
      chk(lo, 4 * dv);
      chk(hi, 7 * dv);
    end
    chk(lo_unf_irq_o, 2);
    chk(hi_unf_irq_o, 3);
    chk(cmp_irq_o, 8'h1B);
  endtask
  // normal and byte modes after three event ticks from 0x5501
  task automatic t_mode();
    int lo, hi;
    for (int m = 0; m < 2; m++)
    begin
      acc(1'b1, sdt_pkg::IDX_CLK_SRC, 8'h00);
      acc(1'b1, sdt_pkg::IDX_MODE, m[7:0]);
      acc(1'b1, sdt_pkg::IDX_HI_COUNT, 8'h55);
      acc(1'b1, sdt_pkg::IDX_LO_COUNT, 8'h01);
      acc(1'b1, sdt_pkg::IDX_CLK_SRC, 8'h08);
      meas(14, 8'h01, lo, hi); // event rises at 2, 6 and 10 only
      rdc(sdt_pkg::IDX_HI_COUNT, m ? 8'h00 : 8'h54);
      rdc(sdt_pkg::IDX_LO_COUNT, m ? 8'h02 : 8'hFE);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    t_defaults();
    t_pins();
    t_cmd();
    t_restart();
    t_run();
    t_mode();
    wrap_up();
  end
endmodule
bind sdt_timer_ctrl sdt_timer_ctrl_chk u_chk (.clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i),
  .waitrequest_o(waitrequest_o), .readdata_o(readdata_o), .event_i(event_i), .port_out_i(port_out_i),
  .pin_o(pin_o), .lo_unf_irq_o(lo_unf_irq_o), .hi_unf_irq_o(hi_unf_irq_o), .cmp_irq_o(cmp_irq_o));
`default_nettype wire
